// file: rtl/pam_decoder.sv
// Address decoder with RAM/ROM remap for the main processor
`timescale 1ns/1ns
module pam_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Remap control written at power-up
  input wire logic remap_write,
  input wire logic remap_value,
  // Processor access
  input wire logic access_valid,
  input wire logic access_write,
  input wire logic [31:0] access_addr,
  // Decoded target
  output logic [3:0] target_region,
  output logic target_select,
  output logic [31:0] target_addr,
  output logic [3:0] debug_slot,
  output logic reserved_hit,
  output logic [31:0] reserved_rdata,
  output logic reserved_ready,
  output logic remap_state
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic remap;
  } pam_state_type;

  pam_state_type state;
  pam_state_type next_state;
  pam_pkg::pam_region_type region;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================================
  // Range table, one entry per decoded address range
  localparam int range_count = 10;
  localparam int idx_swap = 3;
  localparam int idx_boot = 9;

  // Lowest address of each range
  localparam logic [31:0] range_lo [range_count] = '{
    pam_pkg::pam_ext_lo_base,
    pam_pkg::pam_emc_base,
    pam_pkg::pam_mon_base,
    pam_pkg::pam_iram_base,
    pam_pkg::pam_dpm_base,
    pam_pkg::pam_dsp_base,
    pam_pkg::pam_dbg_base,
    pam_pkg::pam_ext_mid_base,
    pam_pkg::pam_ext_hi_base,
    pam_pkg::pam_boot_base
  };

  // Highest address of each range
  localparam logic [31:0] range_hi [range_count] = '{
    pam_pkg::pam_ext_lo_top,
    pam_pkg::pam_emc_top,
    pam_pkg::pam_mon_top,
    pam_pkg::pam_iram_swap_top,
    pam_pkg::pam_dpm_top,
    pam_pkg::pam_dsp_top,
    pam_pkg::pam_dbg_rsv_base - 32'h0000_0001,
    pam_pkg::pam_ext_mid_top,
    pam_pkg::pam_ext_hi_top,
    pam_pkg::pam_boot_top
  };

  // Fixed target of each range; the two swap windows are resolved below
  localparam pam_pkg::pam_region_type range_code [range_count] = '{
    pam_pkg::pam_reg_ext_mem,
    pam_pkg::pam_reg_emc_cfg,
    pam_pkg::pam_reg_bus_mon,
    pam_pkg::pam_reg_none,
    pam_pkg::pam_reg_dual_port,
    pam_pkg::pam_reg_dsp,
    pam_pkg::pam_reg_debug,
    pam_pkg::pam_reg_ext_mem,
    pam_pkg::pam_reg_ext_mem,
    pam_pkg::pam_reg_none
  };

  logic [range_count-1:0] range_hit;

  // Window compare, one per range
  genvar gi;
  generate
    for (gi = 0; gi < range_count; gi++) begin : g_range
      assign range_hit[gi] = in_range(access_addr, range_lo[gi], range_hi[gi]);
    end
  endgenerate

  // ==========================================================================
  // Internal RAM banks
  localparam int bank_count = 3;

  // Lowest address of each bank
  localparam logic [31:0] bank_lo [bank_count] = '{
    pam_pkg::pam_iram_base,
    pam_pkg::pam_iram_one_base,
    pam_pkg::pam_iram_two_base
  };

  // Highest address of each bank
  localparam logic [31:0] bank_hi [bank_count] = '{
    pam_pkg::pam_iram_one_base - 32'h0000_0001,
    pam_pkg::pam_iram_swap_top,
    pam_pkg::pam_iram_two_top
  };

  // Region code of each bank
  localparam pam_pkg::pam_region_type bank_code [bank_count] = '{
    pam_pkg::pam_reg_ram_zero,
    pam_pkg::pam_reg_ram_one,
    pam_pkg::pam_reg_ram_two
  };

  logic [bank_count-1:0] bank_hit;

  // Bank compare, one per bank
  genvar gb;
  generate
    for (gb = 0; gb < bank_count; gb++) begin : g_bank
      assign bank_hit[gb] = in_range(access_addr, bank_lo[gb], bank_hi[gb]);
    end
  endgenerate

  // ==========================================================================
  // Address helpers
  // Boot window answers from ROM until the remap bit hands it to RAM
  function automatic pam_pkg::pam_region_type boot_target(input logic remap);
    if (remap) begin
      boot_target = pam_pkg::pam_reg_ram_zero;
    end else begin
      boot_target = pam_pkg::pam_reg_rom;
    end
  endfunction

  function automatic logic [31:0] window_offset(input logic [31:0] a);
    window_offset = {17'h0_0000, a[pam_pkg::pam_win_width-1:0]};
  endfunction

  function automatic logic [31:0] dsp_offset(input logic [31:0] a);
    dsp_offset = a & pam_pkg::pam_dsp_mask;
  endfunction

  // ==========================================================================
  // Remap bit
  always_comb begin
    next_state = state;
    if (remap_write) begin
      next_state.remap = remap_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state.remap <= pam_pkg::pam_remap_reset;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Region decode, one region per address
  always_comb begin
    region = pam_pkg::pam_reg_none;
    // Fixed ranges never overlap, so at most one entry hits
    for (int i = 0; i < range_count; i++) begin
      if (range_hit[i]) begin
        region = range_code[i];
      end
    end

    // RAM banks answer unless the remap bit hands the low window to ROM
    for (int j = 0; j < bank_count; j++) begin
      if (bank_hit[j]) begin
        region = bank_code[j];
      end
    end
    // Remap read from the register, so a remap write applies from the next cycle's access
    if (range_hit[idx_swap] && state.remap) begin
      region = pam_pkg::pam_reg_rom;
    end

    // Boot window
    if (range_hit[idx_boot]) begin
      region = boot_target(state.remap);
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    target_region = region;
    target_select = access_valid && (region != pam_pkg::pam_reg_none);
    reserved_hit = access_valid && (region == pam_pkg::pam_reg_none);
    reserved_ready = reserved_hit;
    reserved_rdata = pam_pkg::pam_read_zero;
    debug_slot = access_addr[pam_pkg::pam_slot_lsb +: pam_pkg::pam_slot_width];
    remap_state = state.remap;
    case (region)
      pam_pkg::pam_reg_dsp: begin
        target_addr = dsp_offset(access_addr);
      end
      pam_pkg::pam_reg_ext_mem: begin
        target_addr = access_addr;
      end
      pam_pkg::pam_reg_rom,
      pam_pkg::pam_reg_ram_zero,
      pam_pkg::pam_reg_ram_one: begin
        // Offset within the 32 KB swap window
        target_addr = window_offset(access_addr);
      end
      default: begin
        target_addr = access_addr;
      end
    endcase
  end

endmodule

// file: rtl/pam_pkg.sv
// Constants, region codes and field layouts of the processor address decoder
package pam_pkg;

  // ==========================================================================
  // Region codes
  typedef enum logic [3:0] {
    pam_reg_none = 4'h0,
    pam_reg_ext_mem = 4'h1,
    pam_reg_emc_cfg = 4'h2,
    pam_reg_bus_mon = 4'h3,
    pam_reg_ram_zero = 4'h4,
    pam_reg_ram_one = 4'h5,
    pam_reg_ram_two = 4'h6,
    pam_reg_rom = 4'h7,
    pam_reg_dual_port = 4'h8,
    pam_reg_dsp = 4'h9,
    pam_reg_debug = 4'ha
  } pam_region_type;

  // ==========================================================================
  // Address ranges
  localparam logic [31:0] pam_ext_lo_base = 32'h0000_0000;
  localparam logic [31:0] pam_ext_lo_top = 32'h0fff_ffff;
  localparam logic [31:0] pam_emc_base = 32'h2000_0000;
  localparam logic [31:0] pam_emc_top = 32'h200f_ffff;
  localparam logic [31:0] pam_mon_base = 32'h20a0_0000;
  localparam logic [31:0] pam_mon_top = 32'h20af_ffff;
  localparam logic [31:0] pam_iram_base = 32'h4000_0000;
  localparam logic [31:0] pam_iram_one_base = 32'h4000_4000;
  localparam logic [31:0] pam_iram_two_base = 32'h4000_8000;
  localparam logic [31:0] pam_iram_two_top = 32'h4000_afff;
  localparam logic [31:0] pam_iram_swap_top = 32'h4000_7fff;
  localparam logic [31:0] pam_dpm_base = 32'h5000_0000;
  localparam logic [31:0] pam_dpm_top = 32'h5000_0fff;
  localparam logic [31:0] pam_dsp_base = 32'h7000_0000;
  localparam logic [31:0] pam_dsp_top = 32'h7fff_ffff;
  localparam logic [31:0] pam_dbg_base = 32'ha000_0000;
  localparam logic [31:0] pam_dbg_rsv_base = 32'ha000_c000;
  localparam logic [31:0] pam_dbg_top = 32'ha000_ffff;
  localparam logic [31:0] pam_ext_mid_base = 32'hc000_0000;
  localparam logic [31:0] pam_ext_mid_top = 32'hcfff_ffff;
  localparam logic [31:0] pam_ext_hi_base = 32'he000_0000;
  localparam logic [31:0] pam_ext_hi_top = 32'hefff_ffff;
  localparam logic [31:0] pam_boot_base = 32'hffff_0000;
  localparam logic [31:0] pam_boot_top = 32'hffff_7fff;

  // ==========================================================================
  // Field layouts and reset values
  localparam int pam_slot_lsb = 12;
  localparam int pam_slot_width = 4;
  localparam int pam_win_width = 15;
  localparam logic [31:0] pam_dsp_mask = 32'h0fff_ffff;
  localparam logic [31:0] pam_read_zero = 32'h0000_0000;
  localparam logic pam_remap_reset = 1'b0;

endpackage

// file: verif/pam_cpu_model.sv
// Processor core issuing decoder accesses
`timescale 1ns/1ns
module pam_cpu_model (
  // Clock
  input wire logic clk,
  // Access
  output logic access_valid,
  output logic access_write,
  output logic [31:0] access_addr
);
  initial begin
    access_valid = 1'b0;
    access_write = 1'b0;
    access_addr = 32'h0;
  end
  task automatic issue(input logic [31:0] addr);
    @(posedge clk);
    access_valid <= 1'b1;
    access_write <= ~access_write;
    access_addr <= addr;
  endtask
  // Released bus shows the inverse of the last address
  task automatic idle;
    @(posedge clk);
    access_valid <= 1'b0;
    access_addr <= ~access_addr;
  endtask
endmodule

// file: verif/pam_decoder_monitor.sv
// Port assertions of the address decoder
`timescale 1ns/1ns
module pam_decoder_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Requests
  input wire logic remap_write,
  input wire logic remap_value,
  input wire logic access_valid,
  input wire logic [31:0] access_addr,
  // Decode
  input wire logic [3:0] target_region,
  input wire logic [31:0] target_addr,
  input wire logic [3:0] debug_slot,
  input wire logic reserved_hit,
  input wire logic reserved_ready,
  input wire logic [31:0] reserved_rdata,
  input wire logic target_select,
  input wire logic remap_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_remap_load: assert property (remap_write |=> remap_state == $past(remap_value))
    else $error("remap not loaded");
  a_remap_hold: assert property (!remap_write |=> $stable(remap_state))
    else $error("remap moved");
  a_emc_cfg: assert property (access_addr[31:20] == 12'h200 |-> target_region == 4'h2)
    else $error("emc config miss");
  a_bus_mon: assert property (access_addr[31:20] == 12'h20a |-> target_region == 4'h3)
    else $error("monitor miss");
  a_ram_window: assert property (access_addr[31:15] == 17'h08000 |->
    target_region == (remap_state ? 4'h7 : (access_addr[14] ? 4'h5 : 4'h4))) else $error("low win");
  a_boot_window: assert property (access_addr[31:15] == 17'h1fffe |->
    target_region == (remap_state ? 4'h4 : 4'h7) && target_addr == {17'h0, access_addr[14:0]})
    else $error("boot window");
  a_dsp_xlat: assert property (access_addr[31:28] == 4'h7 |->
    target_region == 4'h9 && target_addr == {4'h0, access_addr[27:0]}) else $error("dsp xlat");
  a_debug_slot: assert property (access_addr[31:14] == 18'h28000 |->
    target_region == 4'ha && debug_slot == access_addr[15:12]) else $error("debug slot");
  a_reserved_zero: assert property (access_valid && access_addr[31:28] == 4'h9 |->
    reserved_hit && reserved_ready && reserved_rdata == 32'h0 && !target_select)
    else $error("reserved hit");
endmodule
bind pam_decoder pam_decoder_monitor mon (
  .clk(clk),
  .reset_n(reset_n),
  .remap_write(remap_write),
  .remap_value(remap_value),
  .access_valid(access_valid),
  .access_addr(access_addr),
  .target_region(target_region),
  .target_addr(target_addr),
  .debug_slot(debug_slot),
  .reserved_hit(reserved_hit),
  .reserved_ready(reserved_ready),
  .reserved_rdata(reserved_rdata),
  .target_select(target_select),
  .remap_state(remap_state)
);

// file: verif/pam_decoder_tb.sv
// Self-checking bench of the address decoder
`timescale 1ns/1ns
module pam_decoder_tb;
  logic clk = 1'b0, reset_n = 1'b0, remap_write = 1'b0, remap_value = 1'b0;
  logic access_valid, access_write, target_select, reserved_hit, reserved_ready, remap_state;
  logic [31:0] access_addr, target_addr, reserved_rdata;
  logic [3:0] target_region, debug_slot;
  int errors = 0, check_count = 0;
  always #5 clk = ~clk;
  pam_cpu_model cpu (
    .clk(clk),
    .access_valid(access_valid),
    .access_write(access_write),
    .access_addr(access_addr)
  );
  pam_decoder dut (
    .clk(clk),
    .reset_n(reset_n),
    .remap_write(remap_write),
    .remap_value(remap_value),
    .access_valid(access_valid),
    .access_write(access_write),
    .access_addr(access_addr),
    .target_region(target_region),
    .target_select(target_select),
    .target_addr(target_addr),
    .debug_slot(debug_slot),
    .reserved_hit(reserved_hit),
    .reserved_rdata(reserved_rdata),
    .reserved_ready(reserved_ready),
    .remap_state(remap_state)
  );
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task look(input logic [31:0] a, input logic [3:0] r);
    logic [31:0] t;
    t = (r == 4'h4 || r == 4'h5 || r == 4'h7) ? {17'h0, a[14:0]} :
        (r == 4'h9) ? {4'h0, a[27:0]} : a;
    cpu.issue(a);
    @(negedge clk);
    chk(target_region, r);
    chk(target_addr, t);
    chk(target_select, r != 4'h0);
    chk(reserved_hit, r == 4'h0);
    chk(reserved_ready, r == 4'h0);
    chk(reserved_rdata, 32'h0);
    if (r == 4'ha) chk(debug_slot, a[15:12]);
  endtask
  task t_map;
    look(32'h0000_1234, 4'h1);
    look(32'h200f_ffff, 4'h2);
    look(32'h2010_0000, 4'h0);
    look(32'h20a0_0000, 4'h3);
    look(32'h4000_3fff, 4'h4);
    look(32'h4000_4000, 4'h5);
    look(32'h4000_afff, 4'h6);
    look(32'h4000_b000, 4'h0);
    look(32'h5000_0fff, 4'h8);
    look(32'h5000_1000, 4'h0);
    look(32'h7fff_fffc, 4'h9);
    look(32'he000_0000, 4'h1);
    look(32'ha000_b000, 4'ha);
    look(32'ha000_c000, 4'h0);
    look(32'h9abc_0000, 4'h0);
    look(32'hffff_7ffc, 4'h7);
  endtask
  task t_remap;
    @(posedge clk);
    remap_write <= 1'b1;
    remap_value <= 1'b1;
    @(posedge clk);
    remap_write <= 1'b0;
    look(32'h4000_0000, 4'h7);
    look(32'hffff_4010, 4'h4);
    look(32'h4000_8000, 4'h6);
  endtask
  task t_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    cpu.idle();
    @(negedge clk);
    chk(remap_state, 1'b0);
    chk(target_select, 1'b0);
    look(32'h4000_0000, 4'h4);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // Remap is written right after power-up, as software must do
    t_remap;
    t_reset;
    t_map;
    end_of_test;
  end
  initial begin
    #20000;
    errors++;
    end_of_test;
  end
endmodule
